// [hdl/ncl_consts.svh]
// Offsets, field positions, reset values and threshold counts of the config store
`ifndef NCL_CONSTS_SVH
`define NCL_CONSTS_SVH

// ----------------------------------------------------------------
// Word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define NCL_IDX_DIE_LOCATION 8'h00
`define NCL_IDX_LOT_WAFER 8'h01
`define NCL_IDX_CONFIG_TYPE 8'h02
`define NCL_IDX_SPARE_BITS 8'h03
`define NCL_IDX_LOCK_MASK 8'h24
`define NCL_IDX_NV_LAST 8'h3F
`define NCL_IDX_SHADOW_BASE 8'h40
`define NCL_IDX_SHADOW_LAST 8'h7F
`define NCL_SHADOW_OFFSET 8'h40
`define NCL_IDX_UNLOCK 8'h80
`define NCL_IDX_DIAG_STATUS 8'h81
`define NCL_IDX_TEST_MODE 8'h82

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define NCL_DATA_W 26
`define NCL_ECC_W 6
`define NCL_LOCK_HI 21
`define NCL_LOCK_LO 18
`define NCL_LOCK_NV 4'hC
`define NCL_LOCK_ALL 4'h3
`define NCL_MASK4_BIT 23
`define NCL_BLOCK_VOL_BIT 16
`define NCL_HIGH_Z_BIT 15
`define NCL_MASK3_BIT 13
`define NCL_MASK2_BIT 12
`define NCL_MASK1_BIT 11
`define NCL_MASK0_BIT 10
`define NCL_MISMATCH_HI 7
`define NCL_MISMATCH_LO 6
`define NCL_FLOW_HI 5
`define NCL_FLOW_LO 3
`define NCL_FHIGH_HI 2
`define NCL_FHIGH_LO 0

// ----------------------------------------------------------------
// Reset image and keys (identity values are arbitrary)
// ----------------------------------------------------------------
`define NCL_RST_LOCK_MASK 26'h0000249
`define NCL_RST_DIE_LOCATION 26'h0123440
`define NCL_RST_LOT_WAFER 26'h00ABCC5
`define NCL_RST_CONFIG_TYPE 26'h0155400
`define NCL_UNLOCK_KEY 16'h5A5A

// ----------------------------------------------------------------
// Angle thresholds in 1/65536 of a turn, from degrees
// ----------------------------------------------------------------
`define NCL_DEG_TO_CNT(d) ((d) * 65536 / 360)
`define NCL_MM_DEG0 3
`define NCL_MM_DEG1 5
`define NCL_MM_DEG2 8
`define NCL_MM_DEG3 12

// ----------------------------------------------------------------
// Field magnitude thresholds in digital codes
// ----------------------------------------------------------------
`define NCL_FLOW_1 16'd9830
`define NCL_FLOW_2 16'd13107
`define NCL_FLOW_3 16'd19661
`define NCL_FLOW_4 16'd22938
`define NCL_FLOW_5 16'd26214
`define NCL_FLOW_6 16'd29491
`define NCL_FLOW_7 16'd32768
`define NCL_FHIGH_0 16'd65535
`define NCL_FHIGH_1 16'd52429
`define NCL_FHIGH_2 16'd45875
`define NCL_FHIGH_3 16'd39322
`define NCL_FHIGH_4 16'd36045
`define NCL_FHIGH_5 16'd32768
`define NCL_FHIGH_6 16'd29491
`define NCL_FHIGH_7 16'd26214

`endif

// [hdl/ncl_pkg.sv]
// Types of the configuration store with lock and error masking
package ncl_pkg;

  // ----------------------------------------------------------------
  // Diagnostic flag positions in the status word
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NCL_F_REF_VOLT = 4'h0,
    NCL_F_THERMAL = 4'h1,
    NCL_F_CLIP = 4'h2,
    NCL_F_OSC = 4'h3,
    NCL_F_ANGLE = 4'h4,
    NCL_F_FIELD_LOW = 4'h5,
    NCL_F_FIELD_HIGH = 4'h6,
    NCL_F_SUP_UNDER = 4'h7,
    NCL_F_SUP_OVER = 4'h8,
    NCL_F_RED_BUF = 4'h9
  } ncl_flag_e;

  // Bus phase, one-hot
  typedef enum logic [1:0] {
    NCL_IDLE = 2'b01,
    NCL_DONE = 2'b10
  } ncl_phase_e;

  // Whole state of the block
  typedef struct packed {
    logic [63:0][31:0] nv;
    logic [27:0][31:0] shadow;
    logic unlocked;
    logic [9:0] diag;
    logic [7:0] test_mode;
    ncl_phase_e phase;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic serial_err;
    logic spi_err;
    logic pwm_err;
    logic pwm_high_z;
    logic pwm_half_freq;
    logic block_vol;
    logic [7:0] test_out;
  } ncl_state_s;

endpackage : ncl_pkg

// [hdl/ncl_config_store.sv]
// Config store: nonvolatile words, shadow copy, write locks and error masking
`include "ncl_consts.svh"

// How it works
// - Any word readable without unlocking
// - Nonvolatile and shadow writes refused until unlock key written
// - Shadow copy lives at 0x64 to 0x7F
// - Word zero holds die row, column
// - Word one holds batch and slice numbers
// - Word two holds config type code
// - Word three spare bits writable once unlocked
// - Lock codes block nonvolatile writes, or nonvolatile and shadow writes
// - Bit 23 masks buffer error from serial
// - Bit 16 blocks volatile test bits
// - Bit 15 picks half frequency or tristate
// - Bit 13 masks angle disagree reporting
// - Bit 12 masks clip and field flags
// - Bit 11 masks thermal check flag
// - Bit 10 masks supply flags, oscillator partly
// - Bits 17 and 8 do nothing
// - Angle disagree above coded threshold
// - Field low compare, code zero disables
// - Field high compare, code zero never trips
// - Any unmasked flag sets serial status bits
module ncl_config_store
  import ncl_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sensor measurements
  input wire logic [15:0] ANGLE_MAIN,
  input wire logic [15:0] ANGLE_REDUNDANT,
  input wire logic [15:0] FIELD_MAGNITUDE,
  // Raw error flags from the monitors
  input wire logic CLIP_FLAG,
  input wire logic THERMAL_CHECK_FLAG,
  input wire logic REFERENCE_VOLTAGE_FAULT,
  input wire logic SUPPLY_UNDER_FLAG,
  input wire logic SUPPLY_OVER_FLAG,
  input wire logic OSCILLATOR_FAULT_FLAG,
  input wire logic REDUNDANT_BUFFER_ERROR,
  // Frame status bits
  output logic SERIAL_STATUS_ERROR_BIT_HI,
  output logic SERIAL_STATUS_ERROR_BIT_LO,
  output logic SPI_STATUS_ERROR_BIT_HI,
  output logic SPI_STATUS_ERROR_BIT_LO,
  // Pulse-width error reporting
  output logic PWM_ERROR,
  output logic PWM_HALF_FREQ,
  output logic PWM_HIGH_Z,
  // Volatile test mode control
  output logic VOLATILE_BLOCKED,
  output logic [7:0] TEST_MODE_OUT
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Check bits: parity over data bits whose position has bit i set
  function automatic logic [5:0] ncl_ecc(input logic [25:0] data);
    logic [5:0] chk;
    logic [5:0] pos;
    chk = 6'h00;
    for (int j = 0; j < `NCL_DATA_W; j++) begin
      pos = 6'(j + 1);
      for (int i = 0; i < `NCL_ECC_W; i++) begin
        if (pos[i]) begin
          chk[i] = chk[i] ^ data[j];
        end
      end
    end
    return chk;
  endfunction

  // Packs data with its check bits into a stored word
  function automatic logic [31:0] ncl_word(input logic [25:0] data);
    return {ncl_ecc(data), data};
  endfunction

  // Angle disagree threshold in counts
  function automatic logic [15:0] ncl_mismatch_thr(input logic [1:0] code);
    unique case (code)
      2'd0: return 16'(`NCL_DEG_TO_CNT(`NCL_MM_DEG0));
      2'd1: return 16'(`NCL_DEG_TO_CNT(`NCL_MM_DEG1));
      2'd2: return 16'(`NCL_DEG_TO_CNT(`NCL_MM_DEG2));
      2'd3: return 16'(`NCL_DEG_TO_CNT(`NCL_MM_DEG3));
    endcase
  endfunction

  // Field low threshold; zero means comparison off
  function automatic logic [15:0] ncl_flow_thr(input logic [2:0] code);
    unique case (code)
      3'd0: return 16'h0000;
      3'd1: return `NCL_FLOW_1;
      3'd2: return `NCL_FLOW_2;
      3'd3: return `NCL_FLOW_3;
      3'd4: return `NCL_FLOW_4;
      3'd5: return `NCL_FLOW_5;
      3'd6: return `NCL_FLOW_6;
      3'd7: return `NCL_FLOW_7;
    endcase
  endfunction

  // Field high threshold; code zero is full scale, never exceeded
  function automatic logic [15:0] ncl_fhigh_thr(input logic [2:0] code);
    unique case (code)
      3'd0: return `NCL_FHIGH_0;
      3'd1: return `NCL_FHIGH_1;
      3'd2: return `NCL_FHIGH_2;
      3'd3: return `NCL_FHIGH_3;
      3'd4: return `NCL_FHIGH_4;
      3'd5: return `NCL_FHIGH_5;
      3'd6: return `NCL_FHIGH_6;
      3'd7: return `NCL_FHIGH_7;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ncl_state_s st; // Registered state
  ncl_state_s next_st; // Next state

  // Decoded bus request
  logic [7:0] idx; // Word index from byte address
  logic is_nv; // Nonvolatile window
  logic is_shadow; // Shadow window with backing word
  logic nv_writable; // Nonvolatile word open to customer
  logic [4:0] sh_slot; // Shadow array slot

  // Live configuration, taken from the shadow copy
  logic [31:0] cfg; // Lock, mask, threshold word
  logic [3:0] lock_code; // Lock field

  // Detection
  logic [15:0] ang_diff; // Forward difference
  logic [15:0] ang_dist; // Shortest distance round the circle
  logic [9:0] raw; // Detected flags this cycle
  logic rep_common; // Unmasked flag for all frames and pwm
  logic rep_status; // Unmasked flag for frame status bits
  logic access; // Access phase of a transfer

  // Address decode
  always_comb begin
    idx = PADDR[9:2];
    is_nv = idx <= `NCL_IDX_NV_LAST;
    // Shadow exists only for the customer words from lock_mask_threshold_word up
    is_shadow = (idx >= (`NCL_IDX_LOCK_MASK + `NCL_SHADOW_OFFSET)) &&
                (idx <= `NCL_IDX_SHADOW_LAST);
    // Identity and factory words are read-only
    nv_writable = (idx == `NCL_IDX_SPARE_BITS) || (idx >= `NCL_IDX_LOCK_MASK);
    sh_slot = 5'(idx - `NCL_IDX_LOCK_MASK - `NCL_SHADOW_OFFSET);
    access = PSEL && PENABLE;
  end

  // Angle and field monitors
  always_comb begin
    cfg = st.shadow[0];
    lock_code = cfg[`NCL_LOCK_HI:`NCL_LOCK_LO];
    ang_diff = ANGLE_MAIN - ANGLE_REDUNDANT;
    ang_dist = ang_diff[15] ? 16'(-ang_diff) : ang_diff;
    raw = 10'h000;
    raw[NCL_F_REF_VOLT] = REFERENCE_VOLTAGE_FAULT;
    raw[NCL_F_THERMAL] = THERMAL_CHECK_FLAG;
    raw[NCL_F_CLIP] = CLIP_FLAG;
    raw[NCL_F_OSC] = OSCILLATOR_FAULT_FLAG;
    raw[NCL_F_ANGLE] = ang_dist >
      ncl_mismatch_thr(cfg[`NCL_MISMATCH_HI:`NCL_MISMATCH_LO]);
    raw[NCL_F_FIELD_LOW] = FIELD_MAGNITUDE <
      ncl_flow_thr(cfg[`NCL_FLOW_HI:`NCL_FLOW_LO]);
    raw[NCL_F_FIELD_HIGH] = FIELD_MAGNITUDE >
      ncl_fhigh_thr(cfg[`NCL_FHIGH_HI:`NCL_FHIGH_LO]);
    raw[NCL_F_SUP_UNDER] = SUPPLY_UNDER_FLAG;
    raw[NCL_F_SUP_OVER] = SUPPLY_OVER_FLAG;
    raw[NCL_F_RED_BUF] = REDUNDANT_BUFFER_ERROR;
  end

  // Mask gating; bits 17, 9 and 8 are never looked at
  always_comb begin
    rep_common =
      (raw[NCL_F_ANGLE] && !cfg[`NCL_MASK3_BIT]) ||
      ((raw[NCL_F_CLIP] || raw[NCL_F_FIELD_HIGH] || raw[NCL_F_FIELD_LOW]) &&
       !cfg[`NCL_MASK2_BIT]) ||
      (raw[NCL_F_THERMAL] && !cfg[`NCL_MASK1_BIT]) ||
      ((raw[NCL_F_REF_VOLT] || raw[NCL_F_SUP_UNDER] || raw[NCL_F_SUP_OVER]) &&
       !cfg[`NCL_MASK0_BIT]);
    // Oscillator fault never reaches the pulse-width path
    rep_status = rep_common || (raw[NCL_F_OSC] && !cfg[`NCL_MASK0_BIT]);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Diagnostic flags stick regardless of masks
    next_st.diag = st.diag | raw;
    // Reporting outputs
    next_st.serial_err = rep_status ||
      (raw[NCL_F_RED_BUF] && !cfg[`NCL_MASK4_BIT]);
    next_st.spi_err = rep_status;
    next_st.pwm_err = rep_common;
    next_st.pwm_high_z = rep_common && cfg[`NCL_HIGH_Z_BIT];
    next_st.pwm_half_freq = rep_common && !cfg[`NCL_HIGH_Z_BIT];
    next_st.block_vol = cfg[`NCL_BLOCK_VOL_BIT];
    // Test bits reach the output only while not blocked
    next_st.test_out = cfg[`NCL_BLOCK_VOL_BIT] ? 8'h00 : st.test_mode;

    unique case (st.phase)
      // First access cycle: prepare answer, hold off with pready low
      NCL_IDLE: begin
        next_st.pready = 1'b0;
        if (access) begin
          next_st.phase = NCL_DONE;
          next_st.pready = 1'b1;
          next_st.pslverr = 1'b0;
          next_st.prdata = 32'h0000_0000;
          if (is_nv) begin
            // Reads need no unlock
            next_st.prdata = st.nv[6'(idx)];
            if (PWRITE && (!st.unlocked || !nv_writable ||
                lock_code == `NCL_LOCK_NV || lock_code == `NCL_LOCK_ALL)) begin
              next_st.pslverr = 1'b1;
            end
          end else if (is_shadow) begin
            next_st.prdata = st.shadow[sh_slot];
            if (PWRITE && (!st.unlocked || lock_code == `NCL_LOCK_ALL)) begin
              next_st.pslverr = 1'b1;
            end
          end else if (idx == `NCL_IDX_UNLOCK) begin
            next_st.prdata = {31'h0, st.unlocked};
          end else if (idx == `NCL_IDX_DIAG_STATUS) begin
            next_st.prdata = {22'h0, st.diag};
          end else if (idx == `NCL_IDX_TEST_MODE) begin
            next_st.prdata = {24'h0, st.test_mode};
          end else begin
            // Unmapped, including shadow slots with no backing word
            next_st.pslverr = 1'b1;
          end
        end
      end
      // Pready high: the write lands on this edge, then release
      NCL_DONE: begin
        next_st.phase = NCL_IDLE;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (access && PWRITE && !st.pslverr) begin
          if (is_nv) begin
            // Check bits regenerated from the data field
            next_st.nv[6'(idx)] = ncl_word(PWDATA[25:0]);
          end else if (is_shadow) begin
            next_st.shadow[sh_slot] = ncl_word(PWDATA[25:0]);
          end else if (idx == `NCL_IDX_UNLOCK) begin
            // Any other value locks again
            next_st.unlocked = PWDATA[15:0] == `NCL_UNLOCK_KEY;
          end else if (idx == `NCL_IDX_DIAG_STATUS) begin
            // Write one to clear; a flag set this cycle survives
            next_st.diag = (st.diag & ~PWDATA[9:0]) | raw;
          end else if (idx == `NCL_IDX_TEST_MODE) begin
            next_st.test_mode = PWDATA[7:0];
          end
        end
      end
      default: begin
        next_st.phase = NCL_IDLE;
        next_st.pready = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers; reset models power-up with the factory image
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st <= '0;
      st.phase <= NCL_IDLE;
      st.nv[`NCL_IDX_DIE_LOCATION] <= ncl_word(`NCL_RST_DIE_LOCATION);
      st.nv[`NCL_IDX_LOT_WAFER] <= ncl_word(`NCL_RST_LOT_WAFER);
      st.nv[`NCL_IDX_CONFIG_TYPE] <= ncl_word(`NCL_RST_CONFIG_TYPE);
      st.nv[`NCL_IDX_LOCK_MASK] <= ncl_word(`NCL_RST_LOCK_MASK);
      // Shadow loaded from the nonvolatile image
      st.shadow[0] <= ncl_word(`NCL_RST_LOCK_MASK);
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flop
  // ----------------------------------------------------------------
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign SERIAL_STATUS_ERROR_BIT_HI = st.serial_err;
  assign SERIAL_STATUS_ERROR_BIT_LO = st.serial_err;
  assign SPI_STATUS_ERROR_BIT_HI = st.spi_err;
  assign SPI_STATUS_ERROR_BIT_LO = st.spi_err;
  assign PWM_ERROR = st.pwm_err;
  assign PWM_HALF_FREQ = st.pwm_half_freq;
  assign PWM_HIGH_Z = st.pwm_high_z;
  assign VOLATILE_BLOCKED = st.block_vol;
  assign TEST_MODE_OUT = st.test_out;

endmodule // ncl_config_store

// [tb/ncl_config_store_monitor.sv]
// Port assertions for the config store, bound into the design
`include "ncl_consts.svh"
module ncl_cfg_mon
  import ncl_pkg::*;
(
  // Clock, reset, bus
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Raw flags
  input wire logic THERMAL_CHECK_FLAG,
  input wire logic REFERENCE_VOLTAGE_FAULT,
  input wire logic REDUNDANT_BUFFER_ERROR,
  // Reporting
  input wire logic SERIAL_STATUS_ERROR_BIT_HI,
  input wire logic SERIAL_STATUS_ERROR_BIT_LO,
  input wire logic SPI_STATUS_ERROR_BIT_HI,
  input wire logic SPI_STATUS_ERROR_BIT_LO,
  input wire logic PWM_ERROR,
  input wire logic PWM_HALF_FREQ,
  input wire logic PWM_HIGH_Z,
  input wire logic VOLATILE_BLOCKED,
  input wire logic [7:0] TEST_MODE_OUT
);
  // --------
  // Tracked live config word and unlock state
  // --------
  logic [25:0] mw;
  logic unl;
  logic pz; // Style bit one cycle late, as the outputs lag
  logic [7:0] ix;
  logic [3:0] lk;
  assign ix = PADDR[9:2];
  assign lk = mw[21:18];
  // Follow completed writes to the shadow word and the unlock word
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mw <= `NCL_RST_LOCK_MASK;
      unl <= 1'b0;
      pz <= 1'b0;
    end else begin
      pz <= mw[15];
      if (PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && ix == 8'h64) begin
        mw <= PWDATA[25:0];
      end
      if (PSEL && PENABLE && PREADY && PWRITE && ix == 8'h80) begin
        unl <= PWDATA[15:0] == `NCL_UNLOCK_KEY;
      end
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  chk_one_wait: assert property (s_setup ##1 s_wait |=> PREADY ##1 !PREADY)
    else $error("ready timing wrong");
  chk_read_ok: assert property (s_wait ##0 (!PWRITE && ix < 8'h40) |=> !PSLVERR)
    else $error("memory read refused");
  chk_locked_wr: assert property (s_wait ##0 (PWRITE && !unl && ix < 8'h80) |=> PSLVERR)
    else $error("locked write accepted");
  chk_nv_refuse: assert property (s_wait ##0 (PWRITE && ix < 8'h40 && (ix < 8'h03
    || (ix > 8'h03 && ix < 8'h24) || lk == 4'hC || lk == 4'h3)) |=> PSLVERR)
    else $error("nonvolatile write accepted");
  chk_shadow_lock: assert property (s_wait ##0 (PWRITE && ix > 8'h63 && ix < 8'h80
    && lk == 4'h3) |=> PSLVERR)
    else $error("shadow write accepted");
  chk_thermal_rep: assert property (THERMAL_CHECK_FLAG && !mw[11]
    |=> SPI_STATUS_ERROR_BIT_HI && PWM_ERROR)
    else $error("thermal flag not reported");
  chk_ref_rep: assert property (REFERENCE_VOLTAGE_FAULT && !mw[10]
    |=> SERIAL_STATUS_ERROR_BIT_HI && SPI_STATUS_ERROR_BIT_HI && PWM_ERROR)
    else $error("reference fault not reported");
  chk_buf_serial: assert property (REDUNDANT_BUFFER_ERROR && !mw[23]
    |=> SERIAL_STATUS_ERROR_BIT_HI)
    else $error("buffer error not reported");
  chk_pwm_style: assert property (PWM_ERROR |-> PWM_HIGH_Z == pz && PWM_HALF_FREQ == !pz)
    else $error("pwm error style wrong");
  chk_status_pair: assert property (SERIAL_STATUS_ERROR_BIT_HI == SERIAL_STATUS_ERROR_BIT_LO
    && SPI_STATUS_ERROR_BIT_HI == SPI_STATUS_ERROR_BIT_LO)
    else $error("status pair split");
  chk_vol_block: assert property (VOLATILE_BLOCKED |-> TEST_MODE_OUT == 8'h00)
    else $error("test bits pass while blocked");
endmodule // ncl_cfg_mon

bind ncl_config_store ncl_cfg_mon i_mon (.*);

// [tb/ncl_host_model.sv]
// Controller model that reads and writes the config store over APB
module ncl_host_model (
  // Clock
  input wire logic CLOCK,
  // Request
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [9:0] PADDR,
  output logic [31:0] PWDATA,
  // Answer
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slow = 1'b0; // Random idle gaps when set
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 10'h000;
    PWDATA = 32'h0;
  end
  // One transfer, held until PREADY is sampled high
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    repeat ((slow ? $urandom_range(3) : 0) + 1) @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1) @(posedge CLOCK);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Released lines carry junk, not the old value
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask
endmodule // ncl_host_model

// [tb/ncl_config_store_tb.sv]
// Self-checking bench for the config store
`include "ncl_consts.svh"
module ncl_config_store_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [9:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [15:0] ANGLE_MAIN = 16'h0000;
  logic [15:0] ANGLE_REDUNDANT = 16'h0000;
  logic [15:0] FIELD_MAGNITUDE = 16'h4E20;
  logic CLIP_FLAG, THERMAL_CHECK_FLAG, REFERENCE_VOLTAGE_FAULT, SUPPLY_UNDER_FLAG;
  logic SUPPLY_OVER_FLAG, OSCILLATOR_FAULT_FLAG, REDUNDANT_BUFFER_ERROR;
  logic SERIAL_STATUS_ERROR_BIT_HI, SERIAL_STATUS_ERROR_BIT_LO;
  logic SPI_STATUS_ERROR_BIT_HI, SPI_STATUS_ERROR_BIT_LO;
  logic PWM_ERROR, PWM_HALF_FREQ, PWM_HIGH_Z, VOLATILE_BLOCKED;
  logic [7:0] TEST_MODE_OUT;
  logic [6:0] fl = 7'h00; // Raw flags, clip in bit 0
  assign {REDUNDANT_BUFFER_ERROR, OSCILLATOR_FAULT_FLAG, SUPPLY_OVER_FLAG, SUPPLY_UNDER_FLAG,
          REFERENCE_VOLTAGE_FAULT, THERMAL_CHECK_FLAG, CLIP_FLAG} = fl;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] q, d;
  logic e;
  logic [25:0] w;
  // Base word: bit 9 set, 3 degree code, field codes 1 and 1
  localparam logic [25:0] BASE = 26'h0000209;
  int mbit[7] = '{12, 11, 10, 10, 10, 10, 23};
  int dpos[7] = '{2, 1, 0, 7, 8, 3, 9};
  int ad[3] = '{546, 547, 64989};
  int fv[6] = '{9829, 9830, 52429, 52430, 0, 65535};
  logic [3:0] lc[3] = '{4'hA, 4'hC, 4'h3};
  logic [7:0] ri[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h64};
  logic [25:0] rv[5] = '{`NCL_RST_DIE_LOCATION, `NCL_RST_LOT_WAFER, `NCL_RST_CONFIG_TYPE,
                         26'h0, `NCL_RST_LOCK_MASK};
  ncl_config_store i_dut (.*);
  ncl_host_model i_host (.*);
  always #50 CLOCK = ~CLOCK;
  // Flag k reported on a path, given the live config word
  function automatic logic rep(int k, logic [25:0] cw, logic [6:0] path);
    return path[k] && !cw[mbit[k]];
  endfunction
  // Circular distance beyond the code-zero limit
  function automatic logic mm(int dd);
    return ((dd > 32768) ? 65536 - dd : dd) > 3 * 65536 / 360;
  endfunction
  // Outside the code-one window; code zero never trips
  function automatic logic fx(int f, int c);
    return c != 0 && (f < 9830 || f > 52429);
  endfunction
  task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(logic [7:0] i, logic [31:0] v);
    i_host.xfer(1'b1, {i, 2'b00}, v, q, e);
  endtask
  task automatic rd(logic [7:0] i);
    i_host.xfer(1'b0, {i, 2'b00}, 32'h0, q, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge CLOCK);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far above the roughly 400 cycles needed
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(79));
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    foreach (ri[k]) begin
      rd(ri[k]);
      cmp("reset word", rv[k], {6'h00, q[25:0]});
      cmp("read refused", 0, e);
    end
    $display("done: reset image");
    d = $urandom;
    wr(8'h03, d);
    cmp("locked write", 1, e);
    wr(8'h80, 32'h5A5A);
    wr(8'h03, d);
    rd(8'h03);
    cmp("spare bits", d[25:0], q[25:0]);
    wr(8'h00, d);
    cmp("id write", 1, e);
    wr(8'h24, d);
    rd(8'h64);
    cmp("shadow kept", `NCL_RST_LOCK_MASK, q[25:0]);
    $display("done: unlock");
    wr(8'h81, 32'h3FF);
    for (int k = 0; k < 7; k++) begin
      for (int m = 0; m < 2; m++) begin
        w = BASE | (26'(m) << mbit[k]) | (26'($urandom_range(1)) << 15);
        w = w | (26'($urandom) & 26'h0020100);
        wr(8'h64, {6'h00, w});
        fl <= 7'(1 << k);
        settle();
        cmp("spi status", rep(k, w, 7'h3F), SPI_STATUS_ERROR_BIT_LO);
        cmp("serial status", rep(k, w, 7'h7F), SERIAL_STATUS_ERROR_BIT_LO);
        cmp("pwm error", rep(k, w, 7'h1F), PWM_ERROR);
        cmp("pwm hi-z", rep(k, w, 7'h1F) & w[15], PWM_HIGH_Z);
        cmp("pwm half", rep(k, w, 7'h1F) & !w[15], PWM_HALF_FREQ);
        fl <= 7'h00;
        rd(8'h81);
        cmp("diag bit", 1, q[dpos[k]]);
        wr(8'h81, 32'h3FF);
      end
    end
    $display("done: masks");
    for (int m = 0; m < 2; m++) begin
      wr(8'h64, {6'h00, BASE | (26'(m) << 13)});
      foreach (ad[j]) begin
        d = $urandom;
        ANGLE_MAIN <= d[15:0];
        ANGLE_REDUNDANT <= d[15:0] + 16'(ad[j]);
        settle();
        cmp("angle status", mm(ad[j]) && m == 0, SPI_STATUS_ERROR_BIT_HI);
      end
      ANGLE_REDUNDANT <= ANGLE_MAIN;
      rd(8'h81);
      cmp("angle diag", 1, q[4]);
      wr(8'h81, 32'h3FF);
    end
    $display("done: angle");
    for (int c = 1; c >= 0; c--) begin
      wr(8'h64, {6'h00, (c != 0) ? BASE : 26'h0000200});
      foreach (fv[j]) begin
        FIELD_MAGNITUDE <= 16'(fv[j]);
        settle();
        cmp("field status", fx(fv[j], c), SPI_STATUS_ERROR_BIT_HI);
      end
      FIELD_MAGNITUDE <= 16'h4E20;
    end
    $display("done: field");
    d = $urandom | 32'h1;
    wr(8'h82, d);
    settle();
    cmp("test mode", d[7:0], TEST_MODE_OUT);
    wr(8'h64, {6'h00, BASE | 26'h0010000});
    settle();
    cmp("blocked", 1, VOLATILE_BLOCKED);
    cmp("test blocked", 0, TEST_MODE_OUT);
    $display("done: test mode");
    i_host.slow = 1'b1;
    foreach (lc[j]) begin
      wr(8'h64, {6'h00, BASE | (26'(lc[j]) << 18)});
      wr(8'h03, 32'h0);
      cmp("nv lock", lc[j] == 4'hC || lc[j] == 4'h3, e);
      wr(8'h64, {6'h00, BASE});
      cmp("shadow lock", lc[j] == 4'h3, e);
    end
    rd(8'h40);
    cmp("unmapped err", 1, e);
    cmp("unmapped data", 0, q);
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    rd(8'h64);
    cmp("reload", `NCL_RST_LOCK_MASK, q[25:0]);
    wr(8'h03, 32'h0);
    cmp("relocked", 1, e);
    $display("done: lock codes");
    final_report();
  end
endmodule // ncl_config_store_tb
